// File: include/ieer_pkg.sv
// package: register map, field layouts, reset values and carriers of the interrupt edge/enable block
package ieer_pkg;

  // register indexes; the byte address is four times the index
  localparam logic [15:0] IEER_IDX_ESEL_LOW = 16'hfff2;
  localparam logic [15:0] IEER_IDX_ESEL_HIGH = 16'hfff3;
  localparam logic [15:0] IEER_IDX_EN_TIMER = 16'hfff4;
  localparam logic [15:0] IEER_IDX_EN_PERIPH = 16'hfff5;
  localparam logic [15:0] IEER_IDX_EN_EXT = 16'hfff6;
  localparam logic [15:0] IEER_IDX_FL_TIMER = 16'hfff7;
  localparam logic [15:0] IEER_IDX_FL_PERIPH = 16'hfff8;
  localparam logic [15:0] IEER_IDX_FL_EXT = 16'hfff9;
  localparam int IEER_ADDR_W = 18;

  // values after reset
  localparam logic [7:0] IEER_RST_ESEL_LOW = 8'h70;
  localparam logic [7:0] IEER_RST_ESEL_HIGH = 8'h00;
  localparam logic [7:0] IEER_RST_EN_TIMER = 8'h10;
  localparam logic [7:0] IEER_RST_EN_PERIPH = 8'h00;
  localparam logic [7:0] IEER_RST_EN_EXT = 8'h00;
  localparam logic [7:0] IEER_RST_FL_TIMER = 8'h10;
  localparam logic [7:0] IEER_RST_FL_PERIPH = 8'h00;
  localparam logic [7:0] IEER_RST_FL_EXT = 8'h00;

  // writable bits and bits that always read as one
  localparam logic [7:0] IEER_WM_ESEL_LOW = 8'h0f;
  localparam logic [7:0] IEER_ONE_ESEL_LOW = 8'h70;
  localparam logic [7:0] IEER_WM_FULL = 8'hff;
  localparam logic [7:0] IEER_WM_TIMER = 8'hcf;
  localparam logic [7:0] IEER_ONE_TIMER = 8'h10;
  localparam logic [7:0] IEER_WM_PERIPH = 8'hd0;
  localparam logic [7:0] IEER_ONE_NONE = 8'h00;

  // bit positions of the single-source fields
  localparam int IEER_B_TIMER_B1 = 7;
  localparam int IEER_B_TIMER_A = 6;
  localparam int IEER_B_DIRECT = 7;
  localparam int IEER_B_CONV = 6;
  localparam int IEER_B_SERIAL1 = 4;
  localparam int IEER_B_SH_TIMER_Y = 7;
  localparam int IEER_B_SH_TIMER_B1 = 6;
  localparam int IEER_B_SH_CONV = 5;

  localparam logic [1:0] IEER_RESP_OKAY = 2'b00;
  localparam logic [1:0] IEER_RESP_SLVERR = 2'b10;

  // edge-sensed pins, sampled synchronously
  typedef struct packed {
    logic [3:0] edge_pin_a;
    logic [7:0] ext_pin_b;
    logic timer_y_event_in;
    logic timer_b1_event_in;
    logic converter_ext_trigger;
  } ieer_pins_s;

  // one-cycle event pulses from on-chip peripherals
  typedef struct packed {
    logic timer_b1_ovf;
    logic timer_a_ovf;
    logic direct_xfer;
    logic conv_end;
    logic serial1_done;
  } ieer_evt_s;

  // per-source requests towards the processor
  typedef struct packed {
    logic [3:0] edge_pin_a;
    logic [7:0] ext_pin_b;
    logic timer_b1_ovf;
    logic timer_a_ovf;
    logic direct_xfer;
    logic conv_end;
    logic serial1_done;
  } ieer_req_s;

endpackage

// File: logic/ieer_top.sv
// interrupt edge select, enable and request flag registers behind an AXI4-Lite slave
// Notes on behaviour
// - eight registers at consecutive indexes, edge select low first, pin flags last.
// - low edge select bits 3..0 pick falling (0) or rising (1); reset falling.
// - low edge select bit 7 reads 0, bits 6..4 read 1; writes ignored.
// - high edge select bit 7 sets polarity for pin b7 and timer-Y input.
// - high edge select bit 6 sets polarity for pin b6 and timer-B1 input.
// - high edge select bit 5 sets polarity for pin b5 and converter trigger.
// - high edge select bits 4..0 pick pin edges; whole register read/write, reset zero.
// - timer enable bit 7 gates timer-B1 overflow requests; reset off.
// - timer enable bit 6 gates timer-A overflow requests; reset off.
// - timer enable bits 3..0 gate edge pin requests; reset off.
// - timer enable resets to 0x10; bit 5 reads 0, bit 4 reads 1.
// - peripheral enable bit 7 gates direct transfer requests; reset off.
// - peripheral enable bit 6 gates conversion-end requests; reset off.
// - peripheral enable bit 4 gates serial channel one done requests; reset off.
// - peripheral enable bits 5 and 3..0 read 0, ignore writes; reset zero.
// - request flags clear only by writing 0; writing 1 never sets them.
// - flag sets on its edge or event, stays until software clears it.
// - with processor mask set, flags still set but no interrupt is raised.
// - external pin enable is eight read/write bits, reset zero, one per pin.
module ieer_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ieer_pkg::ieer_pins_s pins,
  input wire ieer_pkg::ieer_evt_s events,
  input wire logic cond_code_mask,
  output ieer_pkg::ieer_req_s src_req,
  output logic cpu_irq,
  output logic [2:0] shared_edge
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [17:0] awaddr;
    logic [7:0] wdata;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] esel_low;
    logic [7:0] esel_high;
    logic [7:0] en_timer;
    logic [7:0] en_periph;
    logic [7:0] en_ext;
    logic [7:0] fl_timer;
    logic [7:0] fl_periph;
    logic [7:0] fl_ext;
    ieer_pkg::ieer_pins_s prev;
    logic primed;
    ieer_pkg::ieer_req_s req;
    logic cpu_irq;
    logic [2:0] shared_edge;
  } ieer_state_s;

  ieer_state_s st_r;
  ieer_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // aligned word inside the eight-register window
  function automatic logic ieer_hit(input logic [17:0] a);
    ieer_hit = (a[1:0] == 2'b00) && (a[17:2] >= ieer_pkg::IEER_IDX_ESEL_LOW)
      && (a[17:2] <= ieer_pkg::IEER_IDX_FL_EXT);
  endfunction

  // keep writable bits, force the bits that always read one
  function automatic logic [7:0] ieer_fix(input logic [7:0] v, input logic [7:0] wm, input logic [7:0] one);
    ieer_fix = (v & wm) | one;
  endfunction

  // edge detector: pol 1 rising, pol 0 falling
  function automatic logic [7:0] ieer_edge(input logic [7:0] cur, input logic [7:0] old, input logic [7:0] pol);
    ieer_edge = (pol & cur & ~old) | (~pol & ~cur & old);
  endfunction

  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic wr_go;
  logic [15:0] widx;
  logic [7:0] clr_timer;
  logic [7:0] clr_periph;
  logic [7:0] clr_ext;
  logic [7:0] set_timer;
  logic [7:0] set_periph;
  logic [7:0] set_ext;
  logic [7:0] pin_a_edge;
  logic [7:0] sh_edge;
  logic [7:0] rd_val;
  logic wr_fl_timer;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on sampled pins

  always_comb begin
    pin_a_edge = ieer_edge({4'h0, pins.edge_pin_a}, {4'h0, st_r.prev.edge_pin_a}, st_r.esel_low) & {8{st_r.primed}};
    set_ext = ieer_edge(pins.ext_pin_b, st_r.prev.ext_pin_b, st_r.esel_high) & {8{st_r.primed}};
    sh_edge = ieer_edge({pins.timer_y_event_in, pins.timer_b1_event_in, pins.converter_ext_trigger, 5'h00},
      {st_r.prev.timer_y_event_in, st_r.prev.timer_b1_event_in, st_r.prev.converter_ext_trigger, 5'h00},
      st_r.esel_high) & {8{st_r.primed}};
  end

  // flag set vectors from edges and peripheral events
  always_comb begin
    set_timer = {4'h0, pin_a_edge[3:0]};
    set_timer[ieer_pkg::IEER_B_TIMER_B1] = events.timer_b1_ovf;
    set_timer[ieer_pkg::IEER_B_TIMER_A] = events.timer_a_ovf;
    set_periph = 8'h00;
    set_periph[ieer_pkg::IEER_B_DIRECT] = events.direct_xfer;
    set_periph[ieer_pkg::IEER_B_CONV] = events.conv_end;
    set_periph[ieer_pkg::IEER_B_SERIAL1] = events.serial1_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux

  always_comb begin
    case (s_axi_araddr[17:2])
      ieer_pkg::IEER_IDX_ESEL_LOW: rd_val = st_r.esel_low;
      ieer_pkg::IEER_IDX_ESEL_HIGH: rd_val = st_r.esel_high;
      ieer_pkg::IEER_IDX_EN_TIMER: rd_val = st_r.en_timer;
      ieer_pkg::IEER_IDX_EN_PERIPH: rd_val = st_r.en_periph;
      ieer_pkg::IEER_IDX_EN_EXT: rd_val = st_r.en_ext;
      ieer_pkg::IEER_IDX_FL_TIMER: rd_val = st_r.fl_timer;
      ieer_pkg::IEER_IDX_FL_PERIPH: rd_val = st_r.fl_periph;
      ieer_pkg::IEER_IDX_FL_EXT: rd_val = st_r.fl_ext;
      default: rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    aw_hs = s_axi_awvalid & st_r.awready;
    w_hs = s_axi_wvalid & st_r.wready;
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wen = s_axi_wstrb[0];
    end
    do_wr = st_nxt.aw_got & st_nxt.w_got & ~st_r.bvalid;
    wr_go = do_wr & st_nxt.wen & ieer_hit(st_nxt.awaddr);
    widx = st_nxt.awaddr[17:2];
    clr_timer = 8'h00;
    clr_periph = 8'h00;
    clr_ext = 8'h00;
    wr_fl_timer = wr_go && (widx == ieer_pkg::IEER_IDX_FL_TIMER);
    // register writes; reserved bits are forced back to their fixed value
    if (wr_go) begin
      case (widx)
        ieer_pkg::IEER_IDX_ESEL_LOW:
          st_nxt.esel_low = ieer_fix(st_nxt.wdata, ieer_pkg::IEER_WM_ESEL_LOW, ieer_pkg::IEER_ONE_ESEL_LOW);
        ieer_pkg::IEER_IDX_ESEL_HIGH: st_nxt.esel_high = st_nxt.wdata;
        ieer_pkg::IEER_IDX_EN_TIMER:
          st_nxt.en_timer = ieer_fix(st_nxt.wdata, ieer_pkg::IEER_WM_TIMER, ieer_pkg::IEER_ONE_TIMER);
        ieer_pkg::IEER_IDX_EN_PERIPH:
          st_nxt.en_periph = ieer_fix(st_nxt.wdata, ieer_pkg::IEER_WM_PERIPH, ieer_pkg::IEER_ONE_NONE);
        ieer_pkg::IEER_IDX_EN_EXT: st_nxt.en_ext = st_nxt.wdata;
        ieer_pkg::IEER_IDX_FL_TIMER: clr_timer = ~st_nxt.wdata;
        ieer_pkg::IEER_IDX_FL_PERIPH: clr_periph = ~st_nxt.wdata;
        ieer_pkg::IEER_IDX_FL_EXT: clr_ext = ~st_nxt.wdata;
        default: clr_ext = 8'h00;
      endcase
    end
    // flags: a set in the same cycle as a clear wins; a one written never sets
    st_nxt.fl_timer = ieer_fix((st_r.fl_timer & ~clr_timer) | set_timer,
      ieer_pkg::IEER_WM_TIMER, ieer_pkg::IEER_ONE_TIMER);
    st_nxt.fl_periph = ieer_fix((st_r.fl_periph & ~clr_periph) | set_periph,
      ieer_pkg::IEER_WM_PERIPH, ieer_pkg::IEER_ONE_NONE);
    st_nxt.fl_ext = (st_r.fl_ext & ~clr_ext) | set_ext;
    // write response once both address and data are in
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = ieer_hit(st_nxt.awaddr) ? ieer_pkg::IEER_RESP_OKAY : ieer_pkg::IEER_RESP_SLVERR;
    end else if (st_r.bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;
    // read: one outstanding, data captured when the address is taken
    if (s_axi_arvalid & st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = ieer_hit(s_axi_araddr) ? rd_val : 8'h00;
      st_nxt.rresp = ieer_hit(s_axi_araddr) ? ieer_pkg::IEER_RESP_OKAY : ieer_pkg::IEER_RESP_SLVERR;
    end else if (st_r.rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = ~st_nxt.rvalid;
    // pin history; edges are ignored until one sample has been taken
    st_nxt.prev = pins;
    st_nxt.primed = 1'b1;
    st_nxt.shared_edge = sh_edge[7:5];
    // requests from the registered flags and enables
    st_nxt.req.edge_pin_a = st_r.fl_timer[3:0] & st_r.en_timer[3:0];
    st_nxt.req.timer_b1_ovf = st_r.fl_timer[ieer_pkg::IEER_B_TIMER_B1]
      & st_r.en_timer[ieer_pkg::IEER_B_TIMER_B1];
    st_nxt.req.timer_a_ovf = st_r.fl_timer[ieer_pkg::IEER_B_TIMER_A]
      & st_r.en_timer[ieer_pkg::IEER_B_TIMER_A];
    st_nxt.req.direct_xfer = st_r.fl_periph[ieer_pkg::IEER_B_DIRECT]
      & st_r.en_periph[ieer_pkg::IEER_B_DIRECT];
    st_nxt.req.conv_end = st_r.fl_periph[ieer_pkg::IEER_B_CONV]
      & st_r.en_periph[ieer_pkg::IEER_B_CONV];
    st_nxt.req.serial1_done = st_r.fl_periph[ieer_pkg::IEER_B_SERIAL1]
      & st_r.en_periph[ieer_pkg::IEER_B_SERIAL1];
    st_nxt.req.ext_pin_b = st_r.fl_ext & st_r.en_ext;
    st_nxt.cpu_irq = (|st_nxt.req) & ~cond_code_mask;
    // synchronous reset to documented values
    if (rst) begin
      st_nxt = '0;
      st_nxt.esel_low = ieer_pkg::IEER_RST_ESEL_LOW;
      st_nxt.esel_high = ieer_pkg::IEER_RST_ESEL_HIGH;
      st_nxt.en_timer = ieer_pkg::IEER_RST_EN_TIMER;
      st_nxt.en_periph = ieer_pkg::IEER_RST_EN_PERIPH;
      st_nxt.en_ext = ieer_pkg::IEER_RST_EN_EXT;
      st_nxt.fl_timer = ieer_pkg::IEER_RST_FL_TIMER;
      st_nxt.fl_periph = ieer_pkg::IEER_RST_FL_PERIPH;
      st_nxt.fl_ext = ieer_pkg::IEER_RST_FL_EXT;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h00_0000, st_r.rdata};
  assign src_req = st_r.req;
  assign cpu_irq = st_r.cpu_irq;
  assign shared_edge = st_r.shared_edge;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_low_fixed_bits: assert property (st_r.esel_low[7:4] == 4'h7)
    else $error("edge select low reserved bits wrong");

  a_timer_en_fixed: assert property (st_r.en_timer[5:4] == 2'b01)
    else $error("timer enable reserved bits wrong");

  a_periph_en_fixed: assert property ((st_r.en_periph & ~ieer_pkg::IEER_WM_PERIPH) == 8'h00)
    else $error("peripheral enable reserved bits set");

  a_rising_sets_flag: assert property (st_r.primed && st_r.esel_low[0] && !st_r.prev.edge_pin_a[0]
    && pins.edge_pin_a[0] |=> st_r.fl_timer[0])
    else $error("rising edge on pin a0 did not set flag");

  a_falling_sets_ext: assert property (st_r.primed && !st_r.esel_high[0] && st_r.prev.ext_pin_b[0]
    && !pins.ext_pin_b[0] |=> st_r.fl_ext[0] ##1 st_r.req.ext_pin_b[0] == $past(st_r.en_ext[0]))
    else $error("falling edge on pin b0 lost");

  a_shared_timer_y: assert property (st_r.primed && st_r.esel_high[7] && !st_r.prev.timer_y_event_in
    && pins.timer_y_event_in |=> shared_edge[2])
    else $error("timer-Y edge not reported");

  a_flag_holds: assert property (st_r.fl_timer[6] && !wr_fl_timer |=> st_r.fl_timer[6])
    else $error("timer-A flag dropped without a clear");

  a_one_never_sets: assert property (wr_fl_timer && st_nxt.wdata[7] && !st_r.fl_timer[7]
    && !events.timer_b1_ovf |=> !st_r.fl_timer[7])
    else $error("writing one set a flag");

  a_req_follows: assert property (##1 st_r.req.serial1_done == $past(st_r.fl_periph[4] & st_r.en_periph[4])
    && st_r.req.conv_end == $past(st_r.fl_periph[6] & st_r.en_periph[6]))
    else $error("request not flag and enable");

  a_mask_blocks: assert property (cond_code_mask |=> !cpu_irq)
    else $error("interrupt raised while masked");

  a_bad_addr_err: assert property (do_wr && !ieer_hit(st_nxt.awaddr) |=> s_axi_bvalid
    && s_axi_bresp == ieer_pkg::IEER_RESP_SLVERR)
    else $error("unmapped write not refused");

  // unmapped or unaligned reads answer an error with zero data
  a_rd_unmapped_zero: assert property (s_axi_arvalid && s_axi_arready && !ieer_hit(s_axi_araddr) |=> s_axi_rvalid
    && s_axi_rresp == ieer_pkg::IEER_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_shared_conv_fall: assert property (st_r.primed && !st_r.esel_high[5] && st_r.prev.converter_ext_trigger
    && !pins.converter_ext_trigger |=> shared_edge[0])
    else $error("converter trigger falling edge not reported");

  a_shared_b1_rise: assert property (st_r.primed && st_r.esel_high[6] && !st_r.prev.timer_b1_event_in
    && pins.timer_b1_event_in |=> shared_edge[1])
    else $error("timer-B1 input edge not reported");

  // a write whose low byte lane is off changes nothing
  a_strobe_off_keeps: assert property (do_wr && !st_nxt.wen |=> $stable(st_r.esel_high)
    && $stable(st_r.en_ext))
    else $error("write without strobe changed a register");

  a_ext_en_lands: assert property (wr_go && widx == ieer_pkg::IEER_IDX_EN_EXT
    |=> st_r.en_ext == $past(st_nxt.wdata))
    else $error("external pin enable write lost");

  a_b1_irq_raised: assert property (st_r.fl_timer[7] && st_r.en_timer[7] && !cond_code_mask
    |=> src_req.timer_b1_ovf && cpu_irq)
    else $error("enabled timer-B1 flag raised no interrupt");

endmodule

// File: testbench/ieer_far_model.sv
// far-side model: interrupt pin levels and one-shot peripheral event pulses
module ieer_far_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire ieer_pkg::ieer_pins_s pin_lvl,
  input wire ieer_pkg::ieer_evt_s evt_req,
  output ieer_pkg::ieer_pins_s pins,
  output ieer_pkg::ieer_evt_s events
);
  timeunit 1ns;
  timeprecision 1ps;
  ieer_pkg::ieer_evt_s req_q;
  //////////////////////////////////////////////////////////////////////////////
  // pins follow the asked levels on the clock; an event pulses for one cycle per request rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pins <= '0;
      events <= '0;
      req_q <= '0;
    end else begin
      pins <= pin_lvl;
      events <= evt_req & ~req_q;
      req_q <= evt_req;
    end
  end
endmodule

// File: testbench/test_interrupt_edge_enable_regs.sv
// self-checking bench of the interrupt edge/enable register block
module test_interrupt_edge_enable_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cond_code_mask = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] shared_edge;
  ieer_pkg::ieer_pins_s pins, pin_lvl = '0;
  ieer_pkg::ieer_evt_s events, evt_req = '0;
  ieer_pkg::ieer_req_s src_req;
  int fails = 0, check_count = 0;
  localparam logic [15:0] IDX [8] = '{ieer_pkg::IEER_IDX_ESEL_LOW, ieer_pkg::IEER_IDX_ESEL_HIGH,
    ieer_pkg::IEER_IDX_EN_TIMER, ieer_pkg::IEER_IDX_EN_PERIPH, ieer_pkg::IEER_IDX_EN_EXT,
    ieer_pkg::IEER_IDX_FL_TIMER, ieer_pkg::IEER_IDX_FL_PERIPH, ieer_pkg::IEER_IDX_FL_EXT};
  localparam logic [7:0] RST_V [8] = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  localparam logic [7:0] ONES_V [5] = '{8'h7f, 8'hff, 8'hdf, 8'hd0, 8'hff};

  ieer_top uut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .events, .cond_code_mask,
    .src_req, .cpu_irq, .shared_edge);
  ieer_far_model far (.core_clk, .rst, .pin_lvl, .evt_req, .pins, .events);

  // clock of 10 ns
  always #5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // AXI4-Lite write: address and data offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0000_00, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // AXI4-Lite read
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [15:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr({idx, 2'b00}, d, 4'h1, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_OKAY}, "write response");
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd({idx, 2'b00}, d, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_OKAY}, "read response");
    chk(d, {24'h0000_00, exp}, "read data");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // reset values, fixed bits and unmapped places
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) rd_chk(IDX[i], RST_V[i]);
    chk({15'h0, src_req}, 32'h0000_0000, "requests after reset");
    for (int i = 0; i < 5; i++) begin
      wr_ok(IDX[i], 8'hff);
      rd_chk(IDX[i], ONES_V[i]);
      wr_ok(IDX[i], 8'h00);
      rd_chk(IDX[i], RST_V[i]);
    end
    for (int i = 5; i < 8; i++) begin
      wr_ok(IDX[i], 8'hff);
      rd_chk(IDX[i], RST_V[i]);
    end
    rd(18'h3_ffe8, d, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0000_0000, "unmapped read data");
    rd(18'h3_ffc9, d, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_SLVERR}, "unaligned read");
    chk(d, 32'h0000_0000, "unaligned read data");
    wr({ieer_pkg::IEER_IDX_EN_EXT, 2'b00}, 8'h5a, 4'h0, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_OKAY}, "strobe off response");
    rd_chk(ieer_pkg::IEER_IDX_EN_EXT, 8'h00);
    wr(18'h3_ffc4, 8'hff, 4'h1, r);
    chk({30'h0, r}, {30'h0, ieer_pkg::IEER_RESP_SLVERR}, "unmapped write");
  endtask

  // edge pins a: polarity, enable gating, interrupt raise and drop, clear by zero
  task automatic t_pins_a();
    wr_ok(ieer_pkg::IEER_IDX_ESEL_LOW, 8'h01);
    wr_ok(ieer_pkg::IEER_IDX_EN_TIMER, 8'h01);
    pin_lvl.edge_pin_a <= 4'b0010;
    repeat (5) @(posedge core_clk);
    pin_lvl.edge_pin_a <= 4'b0001;
    repeat (6) @(posedge core_clk);
    rd_chk(ieer_pkg::IEER_IDX_FL_TIMER, 8'h13);
    chk({15'h0, src_req}, 32'h0000_2000, "pin a requests");
    chk({31'h0, cpu_irq}, 32'h1, "irq raised");
    wr_ok(ieer_pkg::IEER_IDX_FL_TIMER, 8'hfe);
    rd_chk(ieer_pkg::IEER_IDX_FL_TIMER, 8'h12);
    repeat (3) @(posedge core_clk);
    chk({15'h0, src_req}, 32'h0000_0000, "pin a cleared");
    chk({31'h0, cpu_irq}, 32'h0, "irq dropped");
    wr_ok(ieer_pkg::IEER_IDX_FL_TIMER, 8'h00);
  endtask

  // peripheral events while masked, then unmasked, then one enable removed
  task automatic t_events();
    wr_ok(ieer_pkg::IEER_IDX_EN_TIMER, 8'hc0);
    wr_ok(ieer_pkg::IEER_IDX_EN_PERIPH, 8'hd0);
    cond_code_mask <= 1'b1;
    evt_req <= 5'b11111;
    @(posedge core_clk);
    evt_req <= 5'b00000;
    repeat (6) @(posedge core_clk);
    rd_chk(ieer_pkg::IEER_IDX_FL_TIMER, 8'hd0);
    rd_chk(ieer_pkg::IEER_IDX_FL_PERIPH, 8'hd0);
    chk({15'h0, src_req}, 32'h0000_001f, "event requests");
    chk({31'h0, cpu_irq}, 32'h0, "masked irq");
    cond_code_mask <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, cpu_irq}, 32'h1, "unmasked irq");
    wr_ok(ieer_pkg::IEER_IDX_EN_PERIPH, 8'h50);
    repeat (3) @(posedge core_clk);
    chk({15'h0, src_req}, 32'h0000_001b, "direct gated off");
    wr_ok(ieer_pkg::IEER_IDX_FL_TIMER, 8'h00);
    wr_ok(ieer_pkg::IEER_IDX_FL_PERIPH, 8'h00);
    rd_chk(ieer_pkg::IEER_IDX_FL_PERIPH, 8'h00);
  endtask

  // pins b and shared inputs: rise then fall with mixed polarity
  task automatic t_pins_b();
    logic [2:0] seen;
    wr_ok(ieer_pkg::IEER_IDX_ESEL_HIGH, 8'hf0);
    wr_ok(ieer_pkg::IEER_IDX_EN_EXT, 8'h0f);
    seen = 3'b000;
    pin_lvl.ext_pin_b <= 8'hff;
    pin_lvl.timer_y_event_in <= 1'b1;
    pin_lvl.timer_b1_event_in <= 1'b1;
    pin_lvl.converter_ext_trigger <= 1'b1;
    repeat (6) begin
      @(posedge core_clk);
      seen = seen | shared_edge;
    end
    chk({29'h0, seen}, 32'h7, "shared rising");
    rd_chk(ieer_pkg::IEER_IDX_FL_EXT, 8'hf0);
    chk({24'h0, src_req.ext_pin_b}, 32'h00, "pin b gated");
    seen = 3'b000;
    pin_lvl <= '0;
    repeat (6) begin
      @(posedge core_clk);
      seen = seen | shared_edge;
    end
    chk({29'h0, seen}, 32'h0, "shared falling ignored");
    rd_chk(ieer_pkg::IEER_IDX_FL_EXT, 8'hff);
    chk({24'h0, src_req.ext_pin_b}, 32'h0f, "pin b requests");
    // shared inputs with falling polarity: rise ignored, fall reported
    wr_ok(ieer_pkg::IEER_IDX_ESEL_HIGH, 8'h00);
    for (int k = 0; k < 2; k++) begin
      seen = 3'b000;
      pin_lvl <= k ? 15'h0000 : 15'h0007;
      repeat (6) begin
        @(posedge core_clk);
        seen = seen | shared_edge;
      end
      chk({29'h0, seen}, k ? 32'h7 : 32'h0, "shared falling polarity");
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_regs();
    t_pins_a();
    t_events();
    t_pins_b();
    wrap_up();
  end

  // watchdog
  initial begin
    #300us;
    fails++;
    wrap_up();
  end
endmodule
